// >>> adc_seq_map.svh
// Purpose: Offsets, field positions and timing counts for the converter sequencer
// Assumes: APB word-aligned registers, 20 MHz clock
// Notes: Widths are fixed; times are given in ns and turned into cycles here
// Operation
// - Each conversion is a 12-bit successive approximation of the input to supply ratio.
// - Measure channels 0..3 drive the select latches to 010, 000, 011 and 001.
// - Supply calibrate and check set the first select latch to route the reference.
// - The sensor supply goes on just before a sequence and off right after it.
// - Plain mode does one conversion per measurement with normal comparator wiring.
// - Compensated mode does a normal and a swapped conversion and adds the two.
// - An input below range returns the all-zeros code.
// - An input above range returns the all-ones twelve-bit code.
// - Either range fault sets the negative flag, and underrange also sets zero.
// - Valid single results lie from 1 to 4094; 0 and 4095 mark range faults.
// - Several measurements return the sum of all their conversion results.
// - Supply calibrate converts the reference into the main working register.
// - Supply check converts the reference and sets flags against that register.
// - The current source runs only while its latch is 1 and the supply is on.
// - The current source drives the selected input, which is also the one converted.
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

`define CODE_W       12
`define ACC_W        20
`define CNT_W        7
`define CODE_MIN     12'h000
`define CODE_MAX     12'hFFF
`define CODE_MSB     12'h800
`define BIT_TOP      4'hB

`define CLK_PERIOD_NS 50
`define SETTLE_NS     200
`define WARM_NS       1000
`define SETTLE_CYC ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WARM_CYC   ((`WARM_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define OFF_CTRL     8'h00
`define OFF_STATUS   8'h04
`define OFF_RESULT   8'h08
`define OFF_INT_STAT 8'h0C
`define OFF_INT_MASK 8'h10

`define EVT_DONE   0
`define EVT_RANGE  1
`define EVT_LOW    2
`define EVT_W      3
`define CTRL_ISRC  0
`define MODE_COMP  7

`endif

// >>> adc_seq_pkg.sv
// Purpose: Types shared by the converter sequencer
// Assumes: Nothing beyond the map header
// Notes: Command codes are left to the tool
package adc_seq_pkg;
  typedef enum logic [1:0] {CMD_MEASURE, CMD_CALIBRATE, CMD_CHECK} cmd_t;
  typedef enum logic [2:0] {S_IDLE, S_WARM, S_CONV, S_SETTLE, S_DECIDE, S_ACCUM,
                            S_FINISH} seq_state_t;
endpackage

// >>> ratiometric_adc_sequencer.sv
// Purpose: Sequencer for a ratiometric SAR converter with supply switching
// Assumes: Comparator output is asynchronous; interpreter logic shares clk
// Notes: Trial code drives an external DAC; comparator high means input above
`timescale 1ns/1ps
`include "adc_seq_map.svh"

module ratiometric_adc_sequencer
  import adc_seq_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Interpreter request side
  input  wire logic        startReq,
  input  cmd_t             startCmd,
  input  wire logic [1:0]  startChan,
  input  wire logic [7:0]  startMode,
  output logic             busy,
  output logic             donePulse,
  output logic [19:0]      mainWorkReg,
  output logic             posFlag,
  output logic             negFlag,
  output logic             zeroFlag,
  // Analog front end
  input  wire logic        compOut,
  output logic [11:0]      trialCode,
  output logic             compSwap,
  output logic             switchedSupply,
  output logic             inputSelectA,
  output logic             inputSelectB,
  output logic             inputSelectC,
  output logic             currentSourceOn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);

  seq_state_t          state_r;
  cmd_t                cmd_r;
  logic [`CNT_W-1:0]   remain_r;
  logic                compMode_r;
  logic                swap_r;
  logic [7:0]          timer_r;
  logic [3:0]          bitIdx_r;
  logic [11:0]         code_r;
  logic [11:0]         convCode_r;
  logic [`ACC_W-1:0]   acc_r;
  logic                under_r;
  logic                over_r;
  logic                supply_r;
  logic                selA_r;
  logic                selB_r;
  logic                selC_r;
  logic                isrcLatch_r;
  logic [`ACC_W-1:0]   work_r;
  logic                pos_r;
  logic                neg_r;
  logic                zero_r;
  logic                done_r;
  logic [`EVT_W-1:0]   intStat_r;
  logic [`EVT_W-1:0]   intMask_r;
  logic                compMeta_r;
  logic                compSync_r;
  logic [31:0]         prdata_r;
  logic                pslverr_r;

  // Comparator is asynchronous to clk; first stage feeds only the second
  always_ff @(posedge clk)
  begin
    compMeta_r  <= compOut;
    compSync_r  <= compMeta_r;
  end

  // Request decode
  wire        startTaken = startReq && (state_r == S_IDLE);
  wire        isMeasure  = (startCmd == CMD_MEASURE);
  wire [6:0]  reqCount   = startMode[`CNT_W-1:0];
  wire [6:0]  countNorm  = (reqCount == 7'h00) ? 7'h01 : reqCount;
  wire        reqComp    = isMeasure && startMode[`MODE_COMP];
  wire        timerZero  = (timer_r == 8'h00);

  // Swapped wiring inverts the comparator sense, so undo it here
  wire        keepBit    = compSync_r ^ swap_r;
  wire [11:0] bitMask    = 12'h001 << bitIdx_r;
  wire [11:0] codeKept   = keepBit ? code_r : (code_r & ~bitMask);
  wire        lastBit    = (bitIdx_r == 4'h0);
  wire        lastConv   = (remain_r == 7'h01);
  wire        needSwap   = compMode_r && !swap_r;
  wire [19:0] convWide   = {8'h00, convCode_r};

  // Range detection on each raw conversion
  wire        convUnder  = (convCode_r == `CODE_MIN);
  wire        convOver   = (convCode_r == `CODE_MAX);

  // Sequencer state machine
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_r    <= S_IDLE;
      cmd_r      <= CMD_MEASURE;
      remain_r   <= 7'h00;
      compMode_r <= 1'b0;
      swap_r     <= 1'b0;
      timer_r    <= 8'h00;
      bitIdx_r   <= 4'h0;
      code_r     <= 12'h000;
      convCode_r <= 12'h000;
      acc_r      <= 20'h00000;
      under_r    <= 1'b0;
      over_r     <= 1'b0;
      supply_r   <= 1'b0;
      selA_r     <= 1'b0;
      selB_r     <= 1'b0;
      selC_r     <= 1'b0;
    end
    else
    begin
      case (state_r)
        S_IDLE:
        begin
          if (startTaken)
          begin
            cmd_r      <= startCmd;
            remain_r   <= isMeasure ? countNorm : 7'h01;
            compMode_r <= reqComp;
            swap_r     <= 1'b0;
            acc_r      <= 20'h00000;
            under_r    <= 1'b0;
            over_r     <= 1'b0;
            supply_r   <= 1'b1;
            timer_r    <= 8'(`WARM_CYC - 1);
            state_r    <= S_WARM;
            if (isMeasure)
            begin
              // Latch pattern per channel; this input also carries the current
              selA_r <= 1'b0;
              selB_r <= !startChan[0];
              selC_r <= startChan[1];
            end
            else
              selA_r <= 1'b1;
          end
        end
        S_WARM:
        begin
          timer_r <= timer_r - 8'h01;
          if (timerZero)
            state_r <= S_CONV;
        end
        S_CONV:
        begin
          code_r   <= `CODE_MSB;
          bitIdx_r <= `BIT_TOP;
          timer_r  <= 8'(`SETTLE_CYC - 1);
          state_r  <= S_SETTLE;
        end
        S_SETTLE:
        begin
          // Settle covers DAC step plus the two synchroniser stages
          timer_r <= timer_r - 8'h01;
          if (timerZero)
            state_r <= S_DECIDE;
        end
        S_DECIDE:
        begin
          if (lastBit)
          begin
            convCode_r <= codeKept;
            state_r    <= S_ACCUM;
          end
          else
          begin
            code_r   <= codeKept | (bitMask >> 1);
            bitIdx_r <= bitIdx_r - 4'h1;
            timer_r  <= 8'(`SETTLE_CYC - 1);
            state_r  <= S_SETTLE;
          end
        end
        S_ACCUM:
        begin
          acc_r <= acc_r + convWide;
          if (convUnder)
            under_r <= 1'b1;
          if (convOver)
            over_r <= 1'b1;
          if (needSwap)
          begin
            swap_r  <= 1'b1;
            state_r <= S_CONV;
          end
          else
          begin
            swap_r <= 1'b0;
            if (lastConv)
            begin
              supply_r <= 1'b0;
              state_r  <= S_FINISH;
            end
            else
            begin
              remain_r <= remain_r - 7'h01;
              state_r  <= S_CONV;
            end
          end
        end
        S_FINISH:
          state_r <= S_IDLE;
        default:
        begin
          supply_r <= 1'b0;
          state_r  <= S_IDLE;
        end
      endcase
    end
  end

  // Result shaping; underrange wins if both faults were seen
  wire        isFinish   = (state_r == S_FINISH);
  wire        rangeFault = under_r || over_r;
  wire [19:0] satCode    = under_r ? 20'h00000 : {8'h00, `CODE_MAX};
  wire        checkGt    = (acc_r > work_r);
  wire        checkLt    = (acc_r < work_r);

  // Status flags written once per finished sequence; working register only by measure and calibrate
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      work_r <= 20'h00000;
      pos_r  <= 1'b0;
      neg_r  <= 1'b0;
      zero_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= isFinish;
      if (isFinish)
      begin
        case (cmd_r)
          CMD_MEASURE:
          begin
            work_r <= rangeFault ? satCode : acc_r;
            pos_r  <= !rangeFault;
            neg_r  <= rangeFault;
            zero_r <= under_r;
          end
          CMD_CALIBRATE:
          begin
            work_r <= acc_r;
            pos_r  <= 1'b0;
            neg_r  <= 1'b0;
            zero_r <= 1'b0;
          end
          CMD_CHECK:
          begin
            pos_r  <= checkGt;
            neg_r  <= checkLt;
            zero_r <= !checkGt && !checkLt;
          end
          default:
          begin
            pos_r  <= 1'b0;
            neg_r  <= 1'b0;
            zero_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // APB decode; zero wait states, unmapped offsets answer with pslverr
  wire apbAccess = psel && penable;
  wire apbWrite  = apbAccess && pwrite;
  wire hitCtrl   = (paddr == `OFF_CTRL);
  wire hitStatus = (paddr == `OFF_STATUS);
  wire hitResult = (paddr == `OFF_RESULT);
  wire hitStat   = (paddr == `OFF_INT_STAT);
  wire hitMask   = (paddr == `OFF_INT_MASK);
  wire hitAny    = hitCtrl || hitStatus || hitResult || hitStat || hitMask;
  wire [`EVT_W-1:0] evtSet;
  wire [`EVT_W-1:0] evtClr;

  assign evtSet[`EVT_DONE]  = isFinish;
  assign evtSet[`EVT_RANGE] = isFinish && (cmd_r == CMD_MEASURE) && rangeFault;
  assign evtSet[`EVT_LOW]   = isFinish && (cmd_r == CMD_CHECK) && checkLt;
  assign evtClr = (apbWrite && hitStat) ? pwdata[`EVT_W-1:0] : 3'b000;

  wire [31:0] rdMux =
    hitCtrl   ? {31'h0, isrcLatch_r} :
    hitStatus ? {28'h0, busy, zero_r, neg_r, pos_r} :
    hitResult ? {12'h000, work_r} :
    hitStat   ? {29'h0, intStat_r} :
    hitMask   ? {29'h0, intMask_r} : 32'h0000_0000;

  // Register file; a new event wins over a same-cycle clear
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      isrcLatch_r <= 1'b0;
      intStat_r   <= 3'b000;
      intMask_r   <= 3'b000;
      prdata_r    <= 32'h0000_0000;
      pslverr_r   <= 1'b0;
    end
    else
    begin
      intStat_r <= (intStat_r & ~evtClr) | evtSet;
      if (apbWrite && hitCtrl)
        isrcLatch_r <= pwdata[`CTRL_ISRC];
      if (apbWrite && hitMask)
        intMask_r <= pwdata[`EVT_W-1:0];
      if (psel && !penable)
      begin
        prdata_r  <= rdMux;
        pslverr_r <= !hitAny;
      end
    end
  end

  // Outputs
  assign busy            = (state_r != S_IDLE);
  assign donePulse       = done_r;
  assign mainWorkReg     = work_r;
  assign posFlag         = pos_r;
  assign negFlag         = neg_r;
  assign zeroFlag        = zero_r;
  assign trialCode       = code_r;
  assign compSwap        = swap_r;
  assign switchedSupply  = supply_r;
  assign inputSelectA    = selA_r;
  assign inputSelectB    = selB_r;
  assign inputSelectC    = selC_r;
  assign currentSourceOn = isrcLatch_r && supply_r;
  assign prdata          = prdata_r;
  assign pready          = 1'b1;
  assign pslverr         = pslverr_r && apbAccess;
  assign irq             = |(intStat_r & intMask_r);

  // Checks on the sequencer
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_supply_off_idle: assert property ((state_r == S_IDLE) |-> !supply_r)
    else $error("Supply on while idle");
  a_supply_on_start: assert property (startTaken |=> supply_r && state_r == S_WARM)
    else $error("Supply not switched on at start");
  a_done_single: assert property (done_r |=> !done_r)
    else $error("Done pulse longer than one cycle");
  // Supply falls on the edge that enters the finish state, so check in that same cycle
  a_done_after_off: assert property ($fell(supply_r) |-> isFinish ##1 done_r)
    else $error("Done not following supply off");
  a_chan0_select: assert property
    (startTaken && isMeasure && startChan == 2'd0 |=> !selA_r && selB_r && !selC_r)
    else $error("Channel 0 select pattern wrong");
  a_chan3_select: assert property
    (startTaken && isMeasure && startChan == 2'd3 |=> !selA_r && !selB_r && selC_r)
    else $error("Channel 3 select pattern wrong");
  a_ref_select: assert property (startTaken && !isMeasure |=> selA_r)
    else $error("Reference not selected");
  a_isrc_gate: assert property (!supply_r |-> !currentSourceOn)
    else $error("Current source on without supply");
  a_swap_mode: assert property (swap_r |-> compMode_r)
    else $error("Swap used in plain mode");
  a_under_flags: assert property
    (done_r && cmd_r == CMD_MEASURE && zero_r |-> neg_r && work_r == 20'h00000)
    else $error("Underrange flags or code wrong");
  a_over_code: assert property
    (done_r && cmd_r == CMD_MEASURE && neg_r && !zero_r |-> work_r == 20'h00FFF)
    else $error("Overrange code wrong");

  c_measure_done: cover property (done_r && cmd_r == CMD_MEASURE && pos_r);
  c_comp_swap:    cover property ($rose(swap_r));
  c_check_low:    cover property (evtSet[`EVT_LOW]);
  c_range_fault:  cover property (evtSet[`EVT_RANGE]);

endmodule

// >>> adc_front_model.sv
// Purpose: Comparator and analog input model facing the sequencer
// Assumes: Levels are codes; the true input sits half a step above each
// Notes: Without sensor supply the comparator answer is worthless
`timescale 1ns/1ps

module adc_front_model
(
  input  wire logic             clk,
  input  wire logic [3:0][11:0] chanLevel,
  input  wire logic [11:0]      refLevel,
  input  wire logic [11:0]      trialCode,
  input  wire logic             compSwap,
  input  wire logic             switchedSupply,
  input  wire logic             inputSelectA,
  input  wire logic             inputSelectB,
  input  wire logic             inputSelectC,
  output logic                  compOut
);
  logic [11:0] level;
  logic        above;
  logic        wander = 1'b0;

  // Addressed input, or the reference when the first latch is set
  assign level = inputSelectA ? refLevel :
                 chanLevel[{inputSelectC, ~inputSelectB}];
  // Ratio to supply is all the code sees; half step avoids ties
  assign above = {level, 1'b1} > {trialCode, 1'b0};
  // Swapped wiring turns the sense round; no supply gives noise
  assign compOut = !switchedSupply ? wander : (compSwap ? ~above : above);

  // Toggling noise so an unpowered read never looks stable
  always @(posedge clk)
    wander <= ~wander;
endmodule

// >>> tb_ratiometric_adc_sequencer.sv
// Purpose: Self-checking bench for the converter sequencer
// Assumes: Comparator model in its own file, one 20 MHz clock
// Notes: Each scenario drives the block and judges the result itself
`timescale 1ns/1ps

module tb_ratiometric_adc_sequencer
  import adc_seq_pkg::*;
;
  localparam logic [11:0] SEL_TAB = 12'b010_000_011_001;
  localparam logic [47:0] EDGE_LVL = {12'h000, 12'h001, 12'hFFE, 12'hFFF};
  localparam logic [11:0] EDGE_FLG = {3'b011, 3'b100, 3'b100, 3'b010};
  localparam logic [35:0] BAT_LVL = {12'h650, 12'h5A0, 12'h600};
  localparam logic [8:0]  BAT_FLG = {3'b100, 3'b010, 3'b001};

  logic             clk = 1'b0;
  logic             sys_rst = 1'b1;
  logic             startReq = 1'b0;
  cmd_t             startCmd = CMD_MEASURE;
  logic [1:0]       startChan = 2'h0;
  logic [7:0]       startMode = 8'h00;
  logic [7:0]       paddr = 8'h00;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [31:0]      pwdata = 32'h0;
  logic             busy, donePulse, posFlag, negFlag, zeroFlag, compOut, compSwap;
  logic             switchedSupply, inputSelectA, inputSelectB, inputSelectC;
  logic             currentSourceOn, pready, pslverr, irq, err;
  logic [19:0]      mainWorkReg;
  logic [11:0]      trialCode, refLevel;
  logic [31:0]      prdata, rd;
  logic [3:0][11:0] chanLevel;
  logic             sawSupply, sawSwap, sawIsrc;
  logic [2:0]       selSeen;
  int               n_errors = 0;
  int               comparisons = 0;
  int               cycles = 0;

  ratiometric_adc_sequencer i_dut (.clk, .sys_rst, .startReq, .startCmd, .startChan,
    .startMode, .busy, .donePulse, .mainWorkReg, .posFlag, .negFlag, .zeroFlag,
    .compOut, .trialCode, .compSwap, .switchedSupply, .inputSelectA, .inputSelectB,
    .inputSelectC, .currentSourceOn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .irq);

  adc_front_model i_front (.clk, .chanLevel, .refLevel, .trialCode, .compSwap,
    .switchedSupply, .inputSelectA, .inputSelectB, .inputSelectC, .compOut);

  // Clock and hang guard; the longest run is about 7900 cycles
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      n_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Hold the request until ready; only the bench timeout ends a stalled wait
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Start pulse, then watch until done; extra adds a start while busy
  task automatic run(input cmd_t c, input logic [1:0] ch, input logic [7:0] md,
                     input logic extra);
    int n;
    @(posedge clk);
    startReq <= 1'b1;
    startCmd <= c;
    startChan <= ch;
    startMode <= md;
    @(posedge clk);
    startReq <= 1'b0;
    {sawSupply, sawSwap, sawIsrc} = 3'b000;
    n = 0;
    while (donePulse !== 1'b1 && n < 20000)
    begin
      @(negedge clk);
      n++;
      sawSupply |= (switchedSupply === 1'b1);
      sawSwap |= (compSwap === 1'b1);
      sawIsrc |= (currentSourceOn === 1'b1);
      if (n == 3)
        selSeen = {inputSelectA, inputSelectB, inputSelectC};
      if (n == 10 && extra)
        @(posedge clk) startReq <= 1'b1;
      if (n == 11 && extra)
        @(posedge clk) startReq <= 1'b0;
    end
    check(n < 20000, 1'b1);
    check({switchedSupply, currentSourceOn}, 2'b00);
    @(negedge clk);
    check({donePulse, busy}, 2'b00);
  endtask

  task automatic t_chan();
    apb(1'b1, 8'h00, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      run(CMD_MEASURE, 2'(i), 8'h01, 1'b0);
      check(selSeen, SEL_TAB[11 - 3 * i -: 3]);
      check(mainWorkReg, chanLevel[i]);
      check({sawSupply, sawSwap, sawIsrc}, 3'b101);
    end
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h1);
    check(err, 1'b0);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, chanLevel[3]);
    apb(1'b1, 8'h00, 32'h0);
    run(CMD_MEASURE, 2'h0, 8'h01, 1'b0);
    check(sawIsrc, 1'b0);
  endtask

  // Compensated sums, maximum count, count of zero, refused restart
  task automatic t_count();
    run(CMD_MEASURE, 2'h1, 8'h83, 1'b1);
    check(mainWorkReg, 6 * chanLevel[1]);
    check({sawSwap, posFlag}, 2'b11);
    run(CMD_MEASURE, 2'h3, 8'h7F, 1'b0);
    check(mainWorkReg, 127 * chanLevel[3]);
    run(CMD_MEASURE, 2'h3, 8'h00, 1'b0);
    check(mainWorkReg, chanLevel[3]);
  endtask

  // Range edges, then an overrange that must not be summed
  task automatic t_range();
    for (int i = 0; i < 4; i++)
    begin
      chanLevel[0] = EDGE_LVL[47 - 12 * i -: 12];
      run(CMD_MEASURE, 2'h0, 8'h01, 1'b0);
      check(mainWorkReg, chanLevel[0]);
      check({posFlag, negFlag, zeroFlag}, EDGE_FLG[11 - 3 * i -: 3]);
    end
    run(CMD_MEASURE, 2'h0, 8'h82, 1'b0);
    check(mainWorkReg, 20'hFFF);
  endtask

  task automatic t_batt();
    run(CMD_CALIBRATE, 2'h0, 8'h00, 1'b0);
    check(selSeen[2], 1'b1);
    check(mainWorkReg, 20'h600);
    for (int i = 0; i < 3; i++)
    begin
      refLevel = BAT_LVL[35 - 12 * i -: 12];
      run(CMD_CHECK, 2'h0, 8'h00, 1'b0);
      check({posFlag, negFlag, zeroFlag}, BAT_FLG[8 - 3 * i -: 3]);
      check(mainWorkReg, 20'h600);
    end
  endtask

  // Sticky events, mask, write-one clear and an unmapped offset
  task automatic t_irq();
    apb(1'b1, 8'h0C, 32'h7);
    apb(1'b1, 8'h10, 32'h0);
    chanLevel[0] = 12'h000;
    run(CMD_MEASURE, 2'h0, 8'h01, 1'b0);
    apb(1'b0, 8'h0C, 32'h0);
    check(rd, 32'h3);
    check(irq, 1'b0);
    apb(1'b1, 8'h10, 32'h1);
    @(negedge clk);
    check(irq, 1'b1);
    apb(1'b1, 8'h0C, 32'h1);
    @(negedge clk);
    check(irq, 1'b0);
    apb(1'b1, 8'h10, 32'h2);
    apb(1'b0, 8'h10, 32'h0);
    check(rd, 32'h2);
    check(irq, 1'b1);
    apb(1'b1, 8'h0C, 32'h2);
    apb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    check({err, irq}, 2'b10);
  endtask

  initial
  begin
    chanLevel = '{12'h0AB, 12'h789, 12'h456, 12'h123};
    refLevel = 12'h600;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    check({busy, donePulse, switchedSupply, currentSourceOn, irq, pready}, 6'h01);
    check({inputSelectA, inputSelectB, inputSelectC, trialCode}, 15'h0);
    t_chan();
    t_count();
    t_range();
    t_batt();
    t_irq();
    summarize();
  end
endmodule
